// *** hw/vic_top.sv ***
`timescale 1ns/1ps
module vic_top
  import vic_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   ext_irq_pin,
  input  wire logic                   pin_change_event,
  input  wire vic_src_vec_t           periph_event,
  input  wire vic_src_vec_t           irq_enable,
  input  wire vic_src_vec_t           flag_clear,
  input  wire logic                   global_irq_on_instr,
  input  wire logic                   global_irq_off_instr,
  input  wire logic                   return_from_isr_instr,
  input  wire logic                   irq_ack,
  input  wire vic_ctx_t               ctx_live,
  output vic_src_vec_t                irq_flags,
  output logic                        global_enable,
  output logic                        irq_req,
  output logic [VIC_VEC_W-1:0]        irq_vector,
  output logic                        irq_taken,
  output logic                        isr_active,
  output vic_ctx_t                    ctx_saved,
  output logic                        ctx_restore
);
  logic                 ext_fall;
  vic_src_vec_t         event_in;
  vic_src_vec_t         pending;
  logic [VIC_VEC_W-1:0] vec_next;
  logic                 any_pending;
  logic                 take;

  vic_ext_filter u_ext_filter (
    .clk        (clk),
    .nrst       (nrst),
    .pin_in     (ext_irq_pin),
    .fall_pulse (ext_fall)
  );

  // Pin change only records while its own enable is set
  always_comb begin
    event_in              = periph_event;
    event_in[VIC_SRC_EXT] = ext_fall;
    event_in[VIC_SRC_PCH] = pin_change_event & irq_enable[VIC_SRC_PCH];
  end

  // Set wins over a software clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < VIC_NSRC; g++) begin : g_flag
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          irq_flags[g] <= 1'b0;
        end else if (event_in[g]) begin
          irq_flags[g] <= 1'b1;
        end else if (flag_clear[g]) begin
          irq_flags[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign pending = irq_flags & irq_enable;

  // Fixed priority: lowest index wins
  always_comb begin
    vec_next    = VIC_VEC_RESET;
    any_pending = 1'b0;
    for (int i = VIC_NSRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        vec_next    = VIC_VEC_TABLE[i*VIC_VEC_W +: VIC_VEC_W];
        any_pending = 1'b1;
      end
    end
  end

  assign irq_req = global_enable & any_pending;
  assign take    = irq_req & irq_ack;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      global_enable <= 1'b0;
    end else if (take) begin
      global_enable <= 1'b0;
    end else if (global_irq_on_instr || return_from_isr_instr) begin
      global_enable <= 1'b1;
    end else if (global_irq_off_instr) begin
      global_enable <= 1'b0;
    end
  end

  // Vector stays until the next accepted interrupt
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_vector <= VIC_VEC_RESET;
      irq_taken  <= 1'b0;
    end else begin
      irq_taken <= take;
      if (take) begin
        irq_vector <= vec_next;
      end
    end
  end

  // One shadow level only: nesting loses the outer context
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctx_saved <= '0;
    end else if (take) begin
      ctx_saved <= ctx_live;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      isr_active  <= 1'b0;
      ctx_restore <= 1'b0;
    end else begin
      ctx_restore <= return_from_isr_instr & isr_active & ~take;
      if (take) begin
        isr_active <= 1'b1;
      end else if (return_from_isr_instr) begin
        isr_active <= 1'b0;
      end
    end
  end
endmodule

// *** inc/vic_pkg.sv ***
package vic_pkg;
  localparam int unsigned   VIC_NSRC      = 11;
  localparam int unsigned   VIC_FILT_LEN  = 4;
  localparam int unsigned   VIC_VEC_W     = 8;
  localparam int unsigned   VIC_STAT_W    = 5;
  localparam int unsigned   VIC_DATA_W    = 8;
  localparam logic [7:0]    VIC_VEC_RESET = 8'h00;

  // Source index order equals priority order, index 0 is highest
  localparam int unsigned   VIC_SRC_EXT   = 0;
  localparam int unsigned   VIC_SRC_PCH   = 1;

  typedef logic [VIC_NSRC-1:0] vic_src_vec_t;

  localparam logic [VIC_NSRC*VIC_VEC_W-1:0] VIC_VEC_TABLE = {
    8'h26, 8'h24, 8'h1e, 8'h1c, 8'h1a, 8'h16, 8'h14, 8'h0c, 8'h06, 8'h04, 8'h02};

  typedef struct packed {
    logic [VIC_DATA_W-1:0] accumulator;
    logic [VIC_STAT_W-1:0] core_status_reg;
    logic [VIC_DATA_W-1:0] indirect_addr_reg;
  } vic_ctx_t;

  typedef enum logic [1:0] {
    VIC_FILT_HIGH = 2'b00,
    VIC_FILT_LOW  = 2'b01
  } vic_filt_state_t;
endpackage

// *** hw/vic_ext_filter.sv ***
`timescale 1ns/1ps
module vic_ext_filter
  import vic_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic pin_in,
  output logic      fall_pulse
);
  logic [1:0]            sync_reg;
  logic [2:0]            cnt_reg;
  vic_filt_state_t       state_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_reg <= 2'b11;
    end else begin
      sync_reg <= {sync_reg[0], pin_in};
    end
  end

  // Level must differ from the filtered state for four clocks in a row
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg    <= 3'h0;
      state_reg  <= VIC_FILT_HIGH;
      fall_pulse <= 1'b0;
    end else begin
      fall_pulse <= 1'b0;
      case (state_reg)
        VIC_FILT_HIGH: begin
          if (sync_reg[1]) begin
            cnt_reg <= 3'h0;
          end else if (cnt_reg == 3'(VIC_FILT_LEN - 1)) begin
            cnt_reg    <= 3'h0;
            state_reg  <= VIC_FILT_LOW;
            fall_pulse <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        VIC_FILT_LOW: begin
          if (!sync_reg[1]) begin
            cnt_reg <= 3'h0;
          end else if (cnt_reg == 3'(VIC_FILT_LEN - 1)) begin
            cnt_reg   <= 3'h0;
            state_reg <= VIC_FILT_HIGH;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        default: begin
          cnt_reg   <= 3'h0;
          state_reg <= VIC_FILT_HIGH;
        end
      endcase
    end
  end
endmodule

// *** tb/vic_core_model.sv ***
`timescale 1ns/1ps
module vic_core_model
  import vic_pkg::*;
(
  input  wire logic clk, nrst, irq_req, slow,
  output logic      irq_ack,
  output vic_ctx_t  ctx_live
);
  logic seen_reg;
  // Slow mode acks a cycle late, like a core ending an instruction
  assign irq_ack = irq_req && (!slow || seen_reg);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen_reg <= 1'b0;
      ctx_live <= '0;
    end else begin
      seen_reg <= irq_req && !irq_ack;
      ctx_live <= vic_ctx_t'(ctx_live + 21'h0a5b3);
    end
  end
endmodule

// *** tb/vic_top_props.sv ***
`timescale 1ns/1ps
module vic_top_props
  import vic_pkg::*;
(
  input wire logic clk, nrst, irq_ack, irq_req, global_enable, irq_taken, isr_active,
  input wire logic global_irq_on_instr, global_irq_off_instr, return_from_isr_instr,
  input wire logic ctx_restore,
  input wire vic_src_vec_t irq_enable, irq_flags,
  input wire logic [VIC_VEC_W-1:0] irq_vector
);
  wire take = irq_req && irq_ack;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_req; irq_req == (global_enable && |(irq_flags & irq_enable)); endproperty
  a_req: assert property (p_req) else $error("request gating");
  property p_take; take |=> irq_taken && isr_active && !global_enable; endproperty
  a_take: assert property (p_take) else $error("take");
  property p_hold; !take |=> $stable(irq_vector) && !irq_taken; endproperty
  a_hold: assert property (p_hold) else $error("vector moved");
  property p_on; global_irq_on_instr && !take |=> global_enable; endproperty
  a_on: assert property (p_on) else $error("enable");
  property p_off; global_irq_off_instr && !global_irq_on_instr
    && !return_from_isr_instr |=> !global_enable; endproperty
  a_off: assert property (p_off) else $error("disable");
  property p_ret; return_from_isr_instr && !take |=> global_enable; endproperty
  a_ret: assert property (p_ret) else $error("return");
  property p_rst; return_from_isr_instr && isr_active && !take
    |=> ctx_restore && !isr_active; endproperty
  a_rst: assert property (p_rst) else $error("restore");
  property p_why; ctx_restore |-> $past(return_from_isr_instr && isr_active); endproperty
  a_why: assert property (p_why) else $error("stray restore");
endmodule
bind vic_top vic_top_props props (.*);

// *** tb/test_vectored_interrupt_controller.sv ***
`timescale 1ns/1ps
module test_vectored_interrupt_controller
  import vic_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b0, ext_irq_pin = 1'b1, slow = 1'b0, pin_change_event = 1'b0;
  logic global_irq_on_instr = 1'b0, global_irq_off_instr = 1'b0;
  logic return_from_isr_instr = 1'b0;
  logic irq_ack, irq_req, global_enable, irq_taken, isr_active, ctx_restore;
  logic [VIC_VEC_W-1:0] irq_vector;
  vic_src_vec_t periph_event = '0, irq_enable = '1, flag_clear = '0, irq_flags;
  vic_ctx_t ctx_live, ctx_saved, ctx_take;
  int errors = 0, samples_checked = 0;
  logic [7:0] vec_row [11] = '{8'h02, 8'h04, 8'h06, 8'h0c, 8'h14, 8'h16, 8'h1a, 8'h1c,
    8'h1e, 8'h24, 8'h26};
  vic_top dut (.*);
  vic_core_model partner (.*);
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (irq_req && irq_ack) ctx_take <= ctx_live;
  task step(); @(posedge clk) #5; endtask
  task chk(input logic [23:0] seen, exp);
    samples_checked++;
    if (seen !== exp) errors++;
    if (seen !== exp) $display("Error %0t: got %h want %h", $time, seen, exp);
  endtask
  task stop_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task drive(input vic_src_vec_t ev, input logic pc, on);
    {periph_event, pin_change_event, global_irq_on_instr} = {ev, pc, on};
    step();
    {periph_event, pin_change_event, global_irq_on_instr} = '0;
  endtask
  // Bounded wait: a missing take ends the run rather than hanging
  task serve(input logic [7:0] v, input logic fin);
    for (int n = 0; n < 20 && irq_taken !== 1'b1; n++) step();
    chk(irq_taken, 1'b1);
    if (irq_taken !== 1'b1) stop_test();
    chk(irq_vector, v);
    chk({global_enable, isr_active, ctx_saved}, {2'b01, ctx_take});
    if (fin) begin
      flag_clear = irq_flags;
      step();
      flag_clear = '0;
      return_from_isr_instr = 1'b1;
      step();
      return_from_isr_instr = 1'b0;
      chk({ctx_restore, global_enable, isr_active}, 3'b110);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #5 nrst = 1'b1;
    chk({irq_flags, global_enable, isr_active}, '0);
    drive('0, 1'b0, 1'b1);
    chk(global_enable, 1'b1);
    for (int i = 0; i < 11; i++) begin
      ext_irq_pin = (i != 0);
      drive(vic_src_vec_t'(i > 1) << i, i == 1, 1'b0);
      repeat (i == 0 ? 3 : 0) step();
      ext_irq_pin = 1'b1;
      serve(vec_row[i], 1'b1);
    end
    $display("vector rows done");
    slow = 1'b1;
    drive(11'h208, 1'b0, 1'b0);
    serve(8'h0c, 1'b0);
    flag_clear = 11'h008;
    step();
    flag_clear = '0;
    drive('0, 1'b0, 1'b1);
    serve(8'h24, 1'b1);
    $display("priority and nesting done");
    {slow, irq_enable, global_irq_off_instr} = {1'b0, 11'h000, 1'b1};
    drive(11'h020, 1'b1, 1'b0);
    global_irq_off_instr = 1'b0;
    chk({irq_flags, irq_req}, {11'h020, 1'b0});
    irq_enable = '1;
    #1 chk(irq_req, 1'b0);
    drive('0, 1'b0, 1'b1);
    serve(8'h16, 1'b1);
    $display("masked flags done");
    ext_irq_pin = 1'b0;
    repeat (3) step();
    ext_irq_pin = 1'b1;
    repeat (12) step();
    chk(irq_flags, '0);
    $display("glitch done");
    stop_test();
  end
endmodule
